// ### bench/mfa_flow_action_tb.sv
// Self-checking bench for the flow action decoder
`timescale 1ns/1ps
module mfa_flow_action_tb;
  import mfa_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i, tag_class_i, src_port_i, out_dest_port_o;
  logic [1:0] tag_bypass_o, validate_o, stat_dest_port_o;
  logic [2:0] hsize_i;
  logic in_valid_i, in_sop_i, in_eop_i, in_egress_i, sa_hit_i, ctrl_pkt_i;
  logic [DATA_W-1:0] in_data_i, out_data_o;
  logic [IDX_W-1:0] sa_index_i, xform_ctx_o;
  logic out_valid_o, out_sop_o, out_eop_o, out_crc_corrupt_o;
  logic out_pkt_error_o, xform_en_o, xform_egress_o, assoc_active_o;
  logic sci_en_o, scb_en_o, end_station_flag_on_o, conf_protect_o;
  logic replay_en_o, stat_valid_o, stat_dropped_o;
  logic [6:0] conf_offset_o;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int k;

  always #10 clock_i = ~clock_i;

  mfa_flow_action u_dut
  (
    .clock_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .in_valid_i, .in_sop_i, .in_eop_i, .in_data_i, .in_egress_i, .sa_hit_i,
    .sa_index_i, .ctrl_pkt_i, .tag_class_i, .src_port_i, .out_valid_o,
    .out_sop_o, .out_eop_o, .out_data_o, .out_dest_port_o,
    .out_crc_corrupt_o, .out_pkt_error_o, .xform_en_o, .xform_egress_o,
    .xform_ctx_o, .assoc_active_o, .sci_en_o, .end_station_flag_on_o,
    .scb_en_o, .tag_bypass_o, .conf_offset_o, .conf_protect_o,
    .replay_en_o, .validate_o, .stat_valid_o, .stat_dest_port_o,
    .stat_dropped_o
  );

  mfa_mac_model u_mac
  (
    .clock_i(clock_i), .pkt_valid_o(in_valid_i), .pkt_sop_o(in_sop_i),
    .pkt_eop_o(in_eop_i), .pkt_data_o(in_data_i), .egress_o(in_egress_i),
    .hit_o(sa_hit_i), .index_o(sa_index_i), .ctrl_o(ctrl_pkt_i),
    .tcls_o(tag_class_i), .src_o(src_port_i), .out_valid_i(out_valid_o),
    .out_sop_i(out_sop_o), .out_eop_i(out_eop_o), .out_data_i(out_data_o),
    .crc_i(out_crc_corrupt_o), .err_i(out_pkt_error_o),
    .stat_valid_i(stat_valid_o), .stat_dest_i(stat_dest_port_o),
    .stat_drop_i(stat_dropped_o)
  );

  task chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'b10;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask : bus

  task stat(input logic [1:0] dst, input logic drp, crc, err, input int nv);
    chk("stat dest", 32'(u_mac.got_dest), 32'(dst));
    chk("out dest", 32'(out_dest_port_o), 32'(dst));
    chk("dropped", 32'(u_mac.got_drop), 32'(drp));
    chk("crc flag", 32'(u_mac.got_crc), 32'(crc));
    chk("err flag", 32'(u_mac.got_err), 32'(err));
    chk("words", 32'(u_mac.nvalid), 32'(nv));
    chk("data", 32'(u_mac.data_bad), 32'h0000_0000);
  endtask : stat

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    {rstn_i, hsel_i, hwrite_i, htrans_i} = '0;
    {haddr_i, hwdata_i} = '0;
    hsize_i = 3'b010;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
    chk("flow reset", rd, FLOW_RST);
    bus(1'b1, 32'h0000_0028, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_0028, 32'h0000_0000, rd);
    chk("status", rd, 32'h0000_0000);
    bus(1'b1, 32'h0000_0080, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_0080, 32'h0000_0000, rd);
    chk("unmapped", rd, 32'h0000_0000);
    chk("resp", 32'(hresp_o), 32'h0000_0000);
    u_mac.send(1'b1, 1'b1, 2'd0, 1'b0, 2'd1, 2'd0, 3);
    stat(PORT_COMMON, 1'b0, 1'b0, 1'b0, 3);
    bus(1'b1, 32'h0000_0004, 32'h001A_B5CA, rd);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
    chk("egress word", rd, 32'h001A_B5CA);
    u_mac.send(1'b1, 1'b1, 2'd1, 1'b0, 2'd1, 2'd0, 2);
    stat(PORT_CONTROLLED, 1'b0, 1'b0, 1'b0, 2);
    chk("xf en", 32'(xform_en_o), 32'h1);
    chk("ctx", 32'(xform_ctx_o), 32'h1);
    chk("xf eg", 32'(xform_egress_o), 32'h1);
    chk("assoc", 32'(assoc_active_o), 32'h1);
    chk("sci", 32'(sci_en_o), 32'h1);
    chk("es", 32'(end_station_flag_on_o), 32'h0);
    chk("scb", 32'(scb_en_o), 32'h1);
    chk("tag byp", 32'(tag_bypass_o), 32'h2);
    chk("cofs", 32'(conf_offset_o), 32'h55);
    chk("cprot", 32'(conf_protect_o), 32'h1);
    bus(1'b1, 32'h0000_000C, 32'h001A_B58A, rd);
    u_mac.send(1'b1, 1'b1, 2'd3, 1'b0, 2'd1, 2'd0, 2);
    chk("no protect", 32'(xform_en_o), 32'h0);
    chk("words np", 32'(u_mac.nvalid), 32'h2);
    for (k = 0; k < 3; k++)
    begin
      bus(1'b1, 32'h0000_0018, 32'h0001_518E | (32'(k) << 9), rd);
      u_mac.send(1'b0, 1'b1, 2'd2, 1'b0, 2'd1, 2'd0, 2);
      stat(PORT_UNCONTROLLED, 1'b0, 1'b0, 1'b0, 2);
      chk("validate", 32'(validate_o), 32'(k));
      chk("replay", 32'(replay_en_o), 32'h1);
      chk("icofs", 32'(conf_offset_o), 32'h2A);
      chk("i sci", 32'(sci_en_o), 32'h0);
      chk("i xf", 32'(xform_en_o & ~xform_egress_o), 32'h1);
    end
    bus(1'b1, 32'h0000_0010, 32'h0001_51DE, rd);
    u_mac.send(1'b0, 1'b1, 2'd0, 1'b0, 2'd1, PORT_COMMON, 2);
    stat(PORT_UNCONTROLLED, 1'b1, 1'b0, 1'b1, 2);
    u_mac.send(1'b0, 1'b1, 2'd0, 1'b0, 2'd1, PORT_RESERVED, 2);
    stat(PORT_UNCONTROLLED, 1'b0, 1'b0, 1'b0, 2);
    for (k = 0; k < 8; k++)
    begin
      bus(1'b1, 32'h0000_0000, 32'({k[2], 1'b1}) | 32'h4 | 32'(k[1:0]) << 4,
          rd);
      u_mac.send(1'b1, 1'b1, 2'd0, 1'b0, 2'd1, 2'd0, 3);
      stat(PORT_RESERVED, 1'b1, k[1:0] == 2'd0, k[1:0] == 2'd1,
           k[1] ? 0 : 3);
      chk("drop xf", 32'(xform_en_o), 32'h0);
    end
    bus(1'b1, 32'h0000_0000, 32'h001A_B5CA, rd);
    bus(1'b1, 32'h0000_0020, 32'h0F0C_0B08, rd);
    bus(1'b1, 32'h0000_0024, 32'h090A_0D0E, rd);
    for (k = 0; k < 8; k++)
    begin
      u_mac.send(1'b1, 1'b0, 2'd0, k[2], k[1:0], 2'd0, 2);
      stat(k[2] ? 2'd3 - k[1:0] : k[1:0], k[0], 1'b0, k[0], 2);
      chk("nm xf", 32'(xform_en_o), 32'h0);
    end
    print_verdict();
  end
endmodule : mfa_flow_action_tb

// ### bench/mfa_mac_model.sv
// MAC-side packet source and statistics sink model
`timescale 1ns/1ps
module mfa_mac_model
(
  // Clock
  input wire logic clock_i,
  // Packet toward the decoder
  output logic pkt_valid_o,
  output logic pkt_sop_o,
  output logic pkt_eop_o,
  output logic [mfa_pkg::DATA_W-1:0] pkt_data_o,
  output logic egress_o,
  output logic hit_o,
  output logic [1:0] index_o,
  output logic ctrl_o,
  output logic [1:0] tcls_o,
  output logic [1:0] src_o,
  // Packet and statistics from the decoder
  input wire logic out_valid_i,
  input wire logic out_sop_i,
  input wire logic out_eop_i,
  input wire logic [mfa_pkg::DATA_W-1:0] out_data_i,
  input wire logic crc_i,
  input wire logic err_i,
  input wire logic stat_valid_i,
  input wire logic [1:0] stat_dest_i,
  input wire logic stat_drop_i
);
  import mfa_pkg::*;
  logic data_bad, got_crc, got_err, got_drop;
  logic [1:0] got_dest;
  logic [DATA_W-1:0] in_q;
  logic [7:0] pid = 8'h00;
  int nvalid;

  initial
  begin
    {pkt_valid_o, pkt_sop_o, pkt_eop_o, egress_o, hit_o, ctrl_o} = '0;
    {index_o, tcls_o, src_o} = '0;
    pkt_data_o = '0;
  end

  task send(input logic eg, hit, input logic [1:0] idx,
            input logic ctl, input logic [1:0] tc, sp, input int n);
    int i;
    {got_crc, got_err, got_drop, got_dest} = 'x;
    data_bad = 1'b0;
    nvalid = 99;
    pid = pid + 8'h01;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock_i);
      pkt_valid_o <= 1'b1;
      pkt_sop_o <= (i == 0);
      pkt_eop_o <= (i == n - 1);
      pkt_data_o <= {pid, 24'h00_0000, 32'(i)};
      if (i == 0)
        {egress_o, hit_o, index_o, ctrl_o, tcls_o, src_o} <=
          {eg, hit, idx, ctl, tc, sp};
    end
    @(posedge clock_i);
    {pkt_valid_o, pkt_sop_o, pkt_eop_o} <= 3'b000;
    pkt_data_o <= ~pkt_data_o;
    repeat (3) @(posedge clock_i);
  endtask : send

  always @(posedge clock_i)
  begin
    if (out_valid_i && out_data_i !== in_q)
      data_bad = 1'b1;
    in_q = pkt_data_o;
    if (out_sop_i)
      nvalid = 0;
    if (out_valid_i)
      nvalid++;
    if (out_eop_i)
      {got_crc, got_err} = {crc_i, err_i};
    if (stat_valid_i)
      {got_dest, got_drop} = {stat_dest_i, stat_drop_i};
  end
endmodule : mfa_mac_model

// ### common/mfa_pkg.sv
// Constants, field layout and register map of the flow action decoder
//
// What this block does
// [RULE1] Transform, then post-process, then update statistics
// [RULE2] Carry two-bit destination port to pipeline output
// [RULE3] Port codes: common, reserved, controlled, uncontrolled
// [RULE4] Egress word holds two-bit flow type
// [RULE5] Ingress word holds two-bit flow type
// [RULE6] Two-bit drop method decides how drops happen
// [RULE7] Egress protect bit, else pass unprotected
// [RULE8] Each action holds an active-association bit
// [RULE9] Egress SCI, ES and SCB enable bits
// [RULE10] Egress count of bypassed VLAN tags
// [RULE11] Egress seven-bit confidentiality offset
// [RULE12] Ingress seven-bit confidentiality offset
// [RULE13] Ingress drop of non-reserved-port packets
// [RULE14] Ingress replay protection enable
// [RULE15] Ingress validation: disabled, check or strict
// [RULE16] Process flows use stored per-flow context
// [RULE17] Unmatched packets use one of eight entries
// [RULE18] Unmatched entries allow only pass or drop
// [RULE19] Unmatched entries give port and drop method
// [RULE20] Drop: bad CRC, error flag, or internal
// [RULE21] Bypass passes frame unchanged
// [RULE22] Reserved flow type code acts as drop
// [RULE23] Latch action at start, hold whole packet
package mfa_pkg;
  localparam int FLOW_CNT = 4;
  localparam int IDX_W = 2;
  localparam int DATA_W = 64;
  // Register byte offsets and reset values
  localparam logic [7:0] EGR_BASE = 8'h00;
  localparam logic [7:0] IGR_BASE = 8'h10;
  localparam logic [7:0] NM_DATA_OFS = 8'h20;
  localparam logic [7:0] NM_CTRL_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [31:0] FLOW_RST = 32'h0000_0000;
  localparam logic [31:0] NM_RST = 32'h0000_0000;
  // Flow type, drop method, port and validation codes
  localparam logic [1:0] FT_BYPASS = 2'b00;
  localparam logic [1:0] FT_DROP = 2'b01;
  localparam logic [1:0] FT_PROCESS = 2'b10;
  localparam logic [1:0] FT_RSVD = 2'b11;
  localparam logic [1:0] DM_CRC = 2'b00;
  localparam logic [1:0] DM_PKTERR = 2'b01;
  localparam logic [1:0] DM_INTERNAL = 2'b10;
  localparam logic [1:0] PORT_COMMON = 2'b00;
  localparam logic [1:0] PORT_RESERVED = 2'b01;
  localparam logic [1:0] PORT_CONTROLLED = 2'b10;
  localparam logic [1:0] PORT_UNCONTROLLED = 2'b11;
  localparam logic [1:0] VF_DISABLED = 2'b00;
  localparam logic [1:0] VF_CHECK = 2'b01;
  localparam logic [1:0] VF_STRICT = 2'b10;
  // Shared field positions (both directions)
  localparam int F_TYPE = 0;
  localparam int F_DEST = 2;
  localparam int F_DROP = 4;
  // Egress-only fields
  localparam int E_PROTECT = 6;
  localparam int E_ASSOC = 7;
  localparam int E_SCI = 8;
  localparam int E_ES = 9;
  localparam int E_SCB = 10;
  localparam int E_TAGBYP = 11;
  localparam int E_COFS = 13;
  localparam int E_CPROT = 20;
  // Ingress-only fields
  localparam int I_DROPNR = 6;
  localparam int I_REPLAY = 7;
  localparam int I_ASSOC = 8;
  localparam int I_VALID = 9;
  localparam int I_COFS = 11;
  // Unmatched entry: one byte per tag class
  localparam int NM_STRIDE = 8;
  localparam int NM_DROP_BIT = 0;
  localparam int NM_DEST = 1;
  localparam int NM_DM = 3;
endpackage : mfa_pkg

// ### hdl/mfa_action_decode.sv
// Combinational decode of one packet's flow action
`timescale 1ns/1ps
module mfa_action_decode
(
  // Selection inputs
  input wire logic egress_i,
  input wire logic sa_hit_i,
  input wire logic ctrl_pkt_i,
  input wire logic [1:0] tag_class_i,
  input wire logic [1:0] src_port_i,
  // Action words
  input wire logic [31:0] egr_word_i,
  input wire logic [31:0] igr_word_i,
  input wire logic [31:0] nm_data_i,
  input wire logic [31:0] nm_ctrl_i,
  // Decoded action
  output logic [1:0] ftype_o,
  output logic [1:0] dest_o,
  output logic [1:0] drop_m_o,
  output logic [31:0] word_o
);
  import mfa_pkg::*;
  logic [31:0] flow_w;
  logic [7:0] nm_e;
  always_comb
  begin
    flow_w = egress_i ? egr_word_i : igr_word_i;
    // [RULE17] eight-entry unmatched select
    nm_e = 8'((ctrl_pkt_i ? nm_ctrl_i : nm_data_i)
      >> (tag_class_i * NM_STRIDE));
    word_o = flow_w;
    if (sa_hit_i)
    begin
      // [RULE4] [RULE5] flow type read
      ftype_o = flow_w[F_TYPE +: 2];
      dest_o = flow_w[F_DEST +: 2];
      drop_m_o = flow_w[F_DROP +: 2];
      // [RULE22] reserved code acts as drop
      if (ftype_o == FT_RSVD)
        ftype_o = FT_DROP;
      // [RULE13] drop non-reserved ingress
      if (!egress_i && flow_w[I_DROPNR] && src_port_i != PORT_RESERVED)
        ftype_o = FT_DROP;
    end
    else
    begin
      word_o = '0;
      // [RULE18] [RULE19] pass or drop only
      ftype_o = nm_e[NM_DROP_BIT] ? FT_DROP : FT_BYPASS;
      dest_o = nm_e[NM_DEST +: 2];
      drop_m_o = nm_e[NM_DM +: 2];
    end
  end
endmodule : mfa_action_decode

// ### hdl/mfa_flow_action.sv
// Flow action decoder: register file, action latch and packet pipeline
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module mfa_flow_action
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Packet input with lookup result
  input wire logic in_valid_i,
  input wire logic in_sop_i,
  input wire logic in_eop_i,
  input wire logic [mfa_pkg::DATA_W-1:0] in_data_i,
  input wire logic in_egress_i,
  input wire logic sa_hit_i,
  input wire logic [mfa_pkg::IDX_W-1:0] sa_index_i,
  input wire logic ctrl_pkt_i,
  input wire logic [1:0] tag_class_i,
  input wire logic [1:0] src_port_i,
  // Packet output
  output logic out_valid_o,
  output logic out_sop_o,
  output logic out_eop_o,
  output logic [mfa_pkg::DATA_W-1:0] out_data_o,
  output logic [1:0] out_dest_port_o,
  output logic out_crc_corrupt_o,
  output logic out_pkt_error_o,
  // Transform controls, held per packet
  output logic xform_en_o,
  output logic xform_egress_o,
  output logic [mfa_pkg::IDX_W-1:0] xform_ctx_o,
  output logic assoc_active_o,
  output logic sci_en_o,
  output logic end_station_flag_on_o,
  output logic scb_en_o,
  output logic [1:0] tag_bypass_o,
  output logic [6:0] conf_offset_o,
  output logic conf_protect_o,
  output logic replay_en_o,
  output logic [1:0] validate_o,
  // Statistics update
  output logic stat_valid_o,
  output logic [1:0] stat_dest_port_o,
  output logic stat_dropped_o
);
  import mfa_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_PKT} mfa_state_type;

  logic [31:0] egress_flow_action [FLOW_CNT];
  logic [31:0] ingress_flow_action [FLOW_CNT];
  logic [31:0] nomatch_action_data_pkts;
  logic [31:0] nomatch_action_ctrl_pkts;
  mfa_state_type state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [1:0] act_ftype;
  logic [1:0] act_drop_m;
  logic [1:0] dec_ftype;
  logic [1:0] dec_dest;
  logic [1:0] dec_drop_m;
  logic [31:0] dec_word;
  logic start;
  logic next_drop;
  logic next_int_drop;
  logic act_int_drop;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    if (a < IGR_BASE)
      r = egress_flow_action[a[3:2]];
    else if (a < NM_DATA_OFS)
      r = ingress_flow_action[a[3:2]];
    else if (a == NM_DATA_OFS)
      r = nomatch_action_data_pkts;
    else if (a == NM_CTRL_OFS)
      r = nomatch_action_ctrl_pkts;
    else if (a == STATUS_OFS)
      r = {26'h0, state == ST_PKT, act_int_drop, act_drop_m,
           act_ftype};
    return r;
  endfunction : reg_read

  // AHB address phase capture, zero wait states
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= 1'b0;
      if (hsel_i && htrans_i[1] && hready_i)
      begin
        wr_pend <= hwrite_i && haddr_i[31:8] == 24'h00_0000;
        wr_addr <= {haddr_i[7:2], 2'b00};
        if (!hwrite_i && haddr_i[31:8] == 24'h00_0000)
          hrdata_o <= reg_read({haddr_i[7:2], 2'b00});
        else
          hrdata_o <= '0;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < FLOW_CNT; i++)
      begin
        egress_flow_action[i] <= FLOW_RST;
        ingress_flow_action[i] <= FLOW_RST;
      end
      nomatch_action_data_pkts <= NM_RST;
      nomatch_action_ctrl_pkts <= NM_RST;
    end
    else if (wr_pend)
    begin
      if (wr_addr < IGR_BASE)
        egress_flow_action[wr_addr[3:2]] <= hwdata_i;
      else if (wr_addr < NM_DATA_OFS)
        ingress_flow_action[wr_addr[3:2]] <= hwdata_i;
      else if (wr_addr == NM_DATA_OFS)
        nomatch_action_data_pkts <= hwdata_i;
      else if (wr_addr == NM_CTRL_OFS)
        nomatch_action_ctrl_pkts <= hwdata_i;
    end
  end

  mfa_action_decode u_decode
  (
    .egress_i(in_egress_i),
    .sa_hit_i(sa_hit_i),
    .ctrl_pkt_i(ctrl_pkt_i),
    .tag_class_i(tag_class_i),
    .src_port_i(src_port_i),
    .egr_word_i(egress_flow_action[sa_index_i]),
    .igr_word_i(ingress_flow_action[sa_index_i]),
    .nm_data_i(nomatch_action_data_pkts),
    .nm_ctrl_i(nomatch_action_ctrl_pkts),
    .ftype_o(dec_ftype),
    .dest_o(dec_dest),
    .drop_m_o(dec_drop_m),
    .word_o(dec_word)
  );

  assign start = in_valid_i && in_sop_i;
  // [RULE20] internal drop chosen before the end
  assign next_drop = dec_ftype == FT_DROP;
  assign next_int_drop = next_drop && dec_drop_m != DM_CRC
    && dec_drop_m != DM_PKTERR;

  // Packet framing state
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      state <= ST_IDLE;
    else if (in_valid_i && in_eop_i)
      state <= ST_IDLE;
    else if (start)
      state <= ST_PKT;
  end

  // [RULE23] action latched once at start of packet
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      act_ftype <= FT_BYPASS;
      act_drop_m <= DM_CRC;
      act_int_drop <= 1'b0;
      out_dest_port_o <= PORT_COMMON;
      xform_en_o <= 1'b0;
      xform_egress_o <= 1'b0;
      xform_ctx_o <= '0;
      assoc_active_o <= 1'b0;
      sci_en_o <= 1'b0;
      end_station_flag_on_o <= 1'b0;
      scb_en_o <= 1'b0;
      tag_bypass_o <= '0;
      conf_offset_o <= '0;
      conf_protect_o <= 1'b0;
      replay_en_o <= 1'b0;
      validate_o <= VF_DISABLED;
    end
    else if (start)
    begin
      act_ftype <= dec_ftype;
      act_drop_m <= dec_drop_m;
      act_int_drop <= next_int_drop;
      // [RULE2] [RULE3] port code carried as is
      out_dest_port_o <= dec_dest;
      xform_egress_o <= in_egress_i;
      // [RULE16] context index follows matched flow
      xform_ctx_o <= sa_index_i;
      if (in_egress_i)
      begin
        // [RULE7] protect bit gates the transform
        xform_en_o <= dec_ftype == FT_PROCESS && dec_word[E_PROTECT];
        // [RULE8] association flag
        assoc_active_o <= dec_word[E_ASSOC];
        // [RULE9] tag option enables
        sci_en_o <= dec_word[E_SCI];
        end_station_flag_on_o <= dec_word[E_ES];
        scb_en_o <= dec_word[E_SCB];
        // [RULE10] bypassed VLAN tag count
        tag_bypass_o <= dec_word[E_TAGBYP +: 2];
        // [RULE11] egress confidentiality offset
        conf_offset_o <= dec_word[E_COFS +: 7];
        conf_protect_o <= dec_word[E_CPROT];
        replay_en_o <= 1'b0;
        validate_o <= VF_DISABLED;
      end
      else
      begin
        xform_en_o <= dec_ftype == FT_PROCESS;
        // [RULE8] association flag
        assoc_active_o <= dec_word[I_ASSOC];
        sci_en_o <= 1'b0;
        end_station_flag_on_o <= 1'b0;
        scb_en_o <= 1'b0;
        tag_bypass_o <= '0;
        // [RULE12] ingress confidentiality offset
        conf_offset_o <= dec_word[I_COFS +: 7];
        conf_protect_o <= 1'b0;
        // [RULE14] replay protection enable
        replay_en_o <= dec_word[I_REPLAY];
        // [RULE15] validation level
        validate_o <= dec_word[I_VALID +: 2];
      end
    end
  end

  // Data stage; internal drops never assert out_valid_o, but out_sop_o and out_eop_o still pulse
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      out_valid_o <= 1'b0;
      out_sop_o <= 1'b0;
      out_eop_o <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      // [RULE20] internal drop suppresses output
      out_valid_o <= in_valid_i && !(start ? next_int_drop : act_int_drop);
      out_sop_o <= in_valid_i && in_sop_i;
      out_eop_o <= in_valid_i && in_eop_i;
      // [RULE21] bypass data forwarded unchanged
      out_data_o <= in_data_i;
    end
  end

  // [RULE1] post-processing flags on the last word
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      out_crc_corrupt_o <= 1'b0;
      out_pkt_error_o <= 1'b0;
    end
    else
    begin
      // [RULE6] drop method picks the flag
      out_crc_corrupt_o <= in_valid_i && in_eop_i
        && (start ? next_drop && dec_drop_m == DM_CRC
                  : act_ftype == FT_DROP && act_drop_m == DM_CRC);
      out_pkt_error_o <= in_valid_i && in_eop_i
        && (start ? next_drop && dec_drop_m == DM_PKTERR
                  : act_ftype == FT_DROP && act_drop_m == DM_PKTERR);
    end
  end

  // [RULE1] statistics after the packet ends
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      stat_valid_o <= 1'b0;
      stat_dest_port_o <= PORT_COMMON;
      stat_dropped_o <= 1'b0;
    end
    else
    begin
      stat_valid_o <= out_eop_o;
      stat_dest_port_o <= out_dest_port_o;
      stat_dropped_o <= act_ftype == FT_DROP;
    end
  end

  sequence s_nomatch_start;
    start && !sa_hit_i;
  endsequence

  sequence s_unprotected_egress;
    start && in_egress_i && sa_hit_i && dec_ftype == FT_PROCESS
      && !dec_word[E_PROTECT];
  endsequence

  AST_DEST_HELD: // [RULE23]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      state == ST_PKT && !start |=> $stable(out_dest_port_o))
    else $error("destination port changed inside a packet");

  AST_STAT_AFTER_EOP: // [RULE1]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_valid_i && in_eop_i ##1 out_eop_o |=> stat_valid_o)
    else $error("statistics pulse missing after packet end");

  AST_STAT_PORT: // [RULE2]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      stat_valid_o |-> stat_dest_port_o == $past(out_dest_port_o))
    else $error("statistics port differs from output port");

  AST_DEST_FROM_FLOW: // [RULE2]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      start && sa_hit_i && in_egress_i
      |=> out_dest_port_o
          == $past(egress_flow_action[sa_index_i][F_DEST +: 2]))
    else $error("destination port differs from flow action");

  AST_INTERNAL_DROP: // [RULE20]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      start && next_int_drop |=> !out_valid_o)
    else $error("internally dropped packet reached output");

  AST_RSVD_AS_DROP: // [RULE22]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      start && sa_hit_i && dec_word[F_TYPE +: 2] == FT_RSVD
      |=> act_ftype == FT_DROP && !xform_en_o)
    else $error("reserved flow type not treated as drop");

  AST_NOMATCH_NO_XFORM: // [RULE18]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_nomatch_start |=> !xform_en_o && act_ftype != FT_PROCESS)
    else $error("unmatched packet got a transform");

  AST_PROTECT_OFF: // [RULE7]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_unprotected_egress ##1 in_valid_i && !start
      |=> !xform_en_o && out_valid_o)
    else $error("unprotected egress frame not passed through");

  AST_BYPASS_DATA: // [RULE21]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_valid_i && act_ftype == FT_BYPASS && !start
      |=> out_valid_o && out_data_o == $past(in_data_i))
    else $error("bypass frame data altered");

  AST_NONRES_DROP: // [RULE13]
    assert property (@(posedge clock_i) disable iff (!rstn_i)
      start && sa_hit_i && !in_egress_i
      && ingress_flow_action[sa_index_i][I_DROPNR]
      && src_port_i != PORT_RESERVED |=> act_ftype == FT_DROP)
    else $error("non-reserved ingress packet not dropped");

endmodule : mfa_flow_action
